// ---- current_duty_pwm.sv ----
// duty-cycle output stage of a current gauge: averages the filtered current over one
// waveform period and shows that average as a 128-level duty cycle during the next period
// assumes curIn is synchronous to ref_clk and already digitally filtered upstream
`timescale 1ns/1ps
`include "pwm_gauge_defines.svh"

// Function
// - the duty cycle is quantised to 128 levels, so it moves only in steps of 1/128.
// - a level code N gives a high time of N plus one half steps out of 128.
// - current maps linearly to duty, zero to 50 %, plus full scale to 95.5 %, minus full scale to 4.5 %.
// - each period after the first shows the average current over the interval just before it.
// - the waveform comes from comparing the shown level code of the averaged current against a digital ramp.
// - the waveform repeats at about 160 Hz and stays between 100 Hz and 250 Hz.
module current_duty_pwm
   import pwm_gauge_pkg::*;
(
   // clock and reset
   input  wire logic                         ref_clk,
   input  wire logic                         rst,
   // filtered current, signed, full scale at +-2048
   input  wire logic signed [`PG_CUR_W-1:0]  curIn,
   // waveform and status
   output pwm_out_s                          pwmStat
);

   // half-step tick divider
   logic [`PG_TICK_W-1:0]     tickQ;
   logic [`PG_TICK_W-1:0]     tickD;
   logic                      tickEnd;

   // ramp position in half steps
   logic [`PG_HALF_W-1:0]     halfQ;
   logic [`PG_HALF_W-1:0]     halfD;
   logic                      periodEnd;

   // current accumulator over one interval
   logic signed [`PG_ACC_W-1:0]  accQ;
   logic signed [`PG_ACC_W-1:0]  accD;
   logic signed [`PG_ACC_W-1:0]  accSum;
   logic signed [`PG_CUR_W-1:0]  avgCur;

   // level mapping
   logic signed [`PG_PROD_W-1:0] prod;
   logic signed [`PG_PROD_W-1:0] scaled;
   level_t                       newLevel;

   // level shown and output state
   level_t                       levelQ;
   level_t                       levelD;
   logic                         pwmQ;
   logic                         pwmD;
   logic                         startQ;
   logic                         startD;
   gauge_state_e                 stateQ;
   gauge_state_e                 stateD;

   // ramp threshold in half steps: 2N+1
   logic [`PG_HALF_W-1:0]        thresh;

   assign tickEnd   = (tickQ == `PG_TICK_W'(`PG_HALF_CYC - 1));
   assign periodEnd = tickEnd && (halfQ == `PG_HALF_W'(`PG_HALF_STEPS - 1));

   // sample the current once per half step, 256 samples per interval
   assign accSum = accQ + `PG_ACC_W'(curIn);

   // average of the 256 samples
   assign avgCur = `PG_CUR_W'(accSum >>> `PG_AVG_SHIFT);

   // linear map with rounding
   assign prod   = `PG_PROD_W'(avgCur) * $signed({1'b0, `PG_GAIN});
   assign scaled = (prod + `PG_ROUND) >>> `PG_GAIN_SHIFT;
   assign newLevel = `PG_ZERO_LEVEL + `PG_LEVEL_W'(scaled);

   // half-step tick divider
   always_comb
   begin
      if (tickEnd)
      begin
         tickD = `PG_RST_TICK;
      end
      else
      begin
         tickD = tickQ + `PG_TICK_W'(1);
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         tickQ <= `PG_RST_TICK;
      end
      else
      begin
         tickQ <= tickD;
      end
   end

   // digital ramp in half steps, wraps at the period end
   always_comb
   begin
      halfD = halfQ;
      if (tickEnd)
      begin
         halfD = halfQ + `PG_HALF_W'(1);
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         halfQ <= `PG_RST_HALF;
      end
      else
      begin
         halfQ <= halfD;
      end
   end

   // accumulator restarts at each period end
   always_comb
   begin
      accD = accQ;
      if (periodEnd)
      begin
         accD = `PG_RST_ACC;
      end
      else if (tickEnd)
      begin
         accD = accSum;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         accQ <= `PG_RST_ACC;
      end
      else
      begin
         accQ <= accD;
      end
   end

   // level load and period start pulse
   always_comb
   begin
      levelD = levelQ;
      startD = 1'b0;
      if (periodEnd)
      begin
         levelD = newLevel;
         startD = 1'b1;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         levelQ <= `PG_ZERO_LEVEL;
         startQ <= 1'b0;
      end
      else
      begin
         levelQ <= levelD;
         startQ <= startD;
      end
   end

   // first interval still running, or a full average is shown
   always_comb
   begin
      stateD = stateQ;
      if (periodEnd)
      begin
         case (stateQ)
            ST_FIRST:
            begin
               stateD = ST_RUN;
            end
            ST_RUN:
            begin
               stateD = ST_RUN;
            end
            default:
            begin
               stateD = ST_FIRST;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         stateQ <= ST_FIRST;
      end
      else
      begin
         stateQ <= stateD;
      end
   end

   // compare against the ramp; odd threshold adds the half step
   always_comb
   begin
      thresh = {levelD, 1'b1};
      pwmD   = (halfD < thresh);
   end

   // ramp rests at half step 0 in reset, below any threshold, so the first pulse is whole
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         pwmQ <= 1'b1;
      end
      else
      begin
         pwmQ <= pwmD;
      end
   end

   assign pwmStat = {pwmQ, startQ, (stateQ == ST_RUN), levelQ};

endmodule // current_duty_pwm

// ---- current_duty_pwm_props.sv ----
// assertions on the duty-cycle output stage
// bound to current_duty_pwm from the testbench top
`timescale 1ns/1ps
`include "pwm_gauge_defines.svh"
module current_duty_pwm_props
   import pwm_gauge_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // design ports
   input wire logic signed [`PG_CUR_W-1:0] curIn,
   input pwm_out_s  pwmStat
);
   int perCnt_q;
   int hiCnt_q;
   always_ff @(posedge ref_clk)
   begin
      perCnt_q <= (rst || pwmStat.periodStart) ? 0 : perCnt_q + 1;
      hiCnt_q  <= (rst || !pwmStat.pwm) ? 0 : hiCnt_q + 1;
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_level_range: assert property (pwmStat.level inside {[7'h06:7'h7a]}) else $error("bad level");
   a_level_hold: assert property ($changed(pwmStat.level) |-> pwmStat.periodStart) else $error("late load");
   a_period_len: assert property (pwmStat.periodStart |-> perCnt_q inside {[40000:100000]}) else $error("rate");
   a_ramp_start: assert property (pwmStat.periodStart |-> pwmStat.pwm && !$past(pwmStat.pwm)) else $error("ramp");
   a_high_time: assert property ($fell(pwmStat.pwm) |-> hiCnt_q == (2 * pwmStat.level + 1) * `PG_HALF_CYC)
      else $error("high time");
   a_measured_rise: assert property ($rose(pwmStat.measured) |-> pwmStat.periodStart) else $error("meas");
   a_measured_keep: assert property (pwmStat.measured |=> pwmStat.measured) else $error("meas drop");
   c_period: cover property (pwmStat.periodStart);
   c_fall: cover property ($fell(pwmStat.pwm));
   c_meas: cover property ($rose(pwmStat.measured));
endmodule // current_duty_pwm_props

// ---- current_duty_pwm_test.sv ----
// self-checking bench for the duty-cycle output stage
// holds one current per period and checks each shown level
`timescale 1ns/1ps
`include "pwm_gauge_defines.svh"
module current_duty_pwm_test
   import pwm_gauge_pkg::*;
;
   logic                        ref_clk = 0;
   logic                        rst = 1;
   logic signed [`PG_CUR_W-1:0] curIn = '0;
   pwm_out_s                    pwmStat;
   int                          code;
   logic                        fresh;
   int                          bad_count = 0;
   int                          compares = 0;
   int                          c0;
   always #50 ref_clk = ~ref_clk;
   current_duty_pwm u_dut (.ref_clk(ref_clk), .rst(rst), .curIn(curIn), .pwmStat(pwmStat));
   pwm_receiver u_rx (.ref_clk(ref_clk), .pwm(pwmStat.pwm), .code(code), .fresh(fresh));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function automatic int lvl(input int c);
      return 64 + ((((256 * c) >>> 8) * 233 + 4096) >>> 13);
   endfunction
   task automatic results();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic wait_start();
      int n;
      n = 0;
      while (pwmStat.periodStart !== 1'b1 && n < 70000)
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      if (n == 70000)
      begin
         bad_count++;
         results();
      end
   endtask
   initial
   begin
      void'($urandom(99));
      c0 = $urandom_range(4095) - 2048;
      repeat (5) @(posedge ref_clk);
      rst <= 1'b0;
      curIn <= c0[`PG_CUR_W-1:0];
      wait_start();
      check(pwmStat.level, lvl(c0));
      check(pwmStat.measured, 1);
      @(posedge ref_clk);
      curIn <= 12'h800;
      #1;
      check(code, 64);
      $display("test 1 done");
      wait_start();
      check(pwmStat.level, lvl(-2048));
      @(posedge ref_clk);
      #1;
      check(code, lvl(c0));
      check(fresh, 1);
      $display("test 2 done");
      results();
   end
endmodule // current_duty_pwm_test
bind current_duty_pwm current_duty_pwm_props u_props (.ref_clk(ref_clk), .rst(rst), .curIn(curIn), .pwmStat(pwmStat));

// ---- pwm_gauge_defines.svh ----
// timing counts, level mapping constants and reset values for the duty-cycle output stage
// assumes a 10 MHz ref_clk and a signed filtered current word from the sensing path
`ifndef PWM_GAUGE_DEFINES_SVH
`define PWM_GAUGE_DEFINES_SVH

// clock and waveform rate
`define PG_CLK_HZ       10000000
`define PG_PWM_HZ       160
`define PG_PWM_MIN_HZ   100
`define PG_PWM_MAX_HZ   250

// quantisation: 128 levels, each split in two half steps
`define PG_LEVELS       128
`define PG_LEVEL_W      7
`define PG_HALF_STEPS   256
`define PG_HALF_W       8

// clock cycles per half step, rounded down (period 62464 cycles, about 160.1 Hz)
`define PG_HALF_CYC     (`PG_CLK_HZ / (`PG_PWM_HZ * `PG_HALF_STEPS))
`define PG_TICK_W       8

// current word and averaging
`define PG_CUR_W        12
`define PG_ACC_W        20
`define PG_AVG_SHIFT    8

// linear map: level = 64 + round(avg * 233 / 8192); 0 -> 50 %, +fs -> 95.5 %, -fs -> 4.5 %
`define PG_ZERO_LEVEL   7'h40
`define PG_GAIN         10'h0e9
`define PG_GAIN_SHIFT   13
`define PG_ROUND        22'sh001000
`define PG_PROD_W       22

// reset values
`define PG_RST_TICK     8'h00
`define PG_RST_HALF     8'h00
`define PG_RST_ACC      20'h00000

`endif

// ---- pwm_gauge_pkg.sv ----
// types shared by the duty-cycle output stage
// constants live in pwm_gauge_defines.svh
`include "pwm_gauge_defines.svh"

package pwm_gauge_pkg;

   typedef enum logic [1:0] {
      ST_FIRST = 2'b01,
      ST_RUN   = 2'b10
   } gauge_state_e;

   typedef logic [`PG_LEVEL_W-1:0] level_t;

   typedef struct packed {
      logic   pwm;
      logic   periodStart;
      logic   measured;
      level_t level;
   } pwm_out_s;

endpackage

// ---- pwm_receiver.sv ----
// receiver model: times the high phase of each waveform period
// assumes the waveform rises at every period start
`timescale 1ns/1ps
`include "pwm_gauge_defines.svh"
module pwm_receiver
(
   // clock and waveform
   input  wire logic ref_clk,
   input  wire logic pwm,
   // decoded level of the last full period
   output int        code,
   output logic      fresh
);
   int   hi;
   logic last;
   always @(posedge ref_clk)
   begin
      last <= pwm;
      fresh <= pwm && !last;
      if (pwm && !last)
      begin
         code <= (hi / `PG_HALF_CYC - 1) / 2;
         hi <= 1;
      end
      else
      begin
         hi <= hi + pwm;
      end
   end
endmodule // pwm_receiver
